// ===== verilog/spr_pkg.sv
// Constants, types and helper functions of the sleep and power reduction controller.
// Assumes one clock (hclk) and an AHB-Lite register port with 32-bit data.
// Summary of operation
// - Sleep starts only when sleep enable is one and the core issues sleep.
// - A three-bit mode field picks one of six sleep modes.
// - After an enabled wake the core is held four cycles past start-up.
// - Register file and data memory keep their contents across sleep.
// - Any reset during sleep wakes the core to the reset vector.
// - Mode 000 is Idle: core clock stops, peripherals keep running.
// - Each mode gates I/O, ADC and asynchronous clock domains as tabled.
// - Outside Idle, external interrupts wake only in level mode; pin change, two-wire match and watchdog always.
// - Async clock and timer oscillator need timer2 async mode; timer2 wake needs it outside Idle.
// - Gate bit 7 stops the two-wire interface clock.
// - Gate bit 6 stops timer2 only while its async select is zero.
// - Gate bit 5 stops timer0, which resumes its state afterwards.
// - Gate bit 3 stops timer1, which resumes its state afterwards.
// - Gate bit 2 stops the SPI clock; not for use under on-chip debug.
// - Gate bit 1 stops the USART clock.
// - With gate bit 0 set the comparator cannot use the ADC mux.
package spr_pkg;
    localparam logic [7:0] SMC_OFS = 8'h60;
    localparam logic [7:0] PCG_OFS = 8'h64;
    localparam logic [7:0] STAT_OFS = 8'h6c;
    localparam logic [7:0] SMC_RESET = 8'h00;
    localparam logic [7:0] PCG_RESET = 8'h00;
    localparam logic [7:0] PCG_MASK = 8'hef;
    localparam int SE_POS = 0;
    localparam int MODE_LSB = 1;
    localparam int MODE_MSB = 3;
    localparam int PCG_TWI = 7;
    localparam int PCG_T2 = 6;
    localparam int PCG_T0 = 5;
    localparam int PCG_T1 = 3;
    localparam int PCG_SPI = 2;
    localparam int PCG_USART = 1;
    localparam int PCG_ADC = 0;
    localparam logic [3:0] HOLD_CYCLES = 4'h4;
    localparam int STARTUP_CYCLES_DEF = 16;
    localparam int CNT_W = 16;

    typedef enum logic [2:0] {
        SPR_IDLE = 3'h0,
        SPR_ADCNR = 3'h1,
        SPR_PDOWN = 3'h2,
        SPR_PSAVE = 3'h3,
        SPR_STDBY = 3'h6,
        SPR_XSTDBY = 3'h7
    } spr_mode_e;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_SLEEP = 4'h2,
        ST_START = 4'h4,
        ST_HOLD = 4'h8
    } spr_state_e;

    function automatic logic spr_mode_ok(input logic [2:0] m);
        return (m != 3'h4) && (m != 3'h5);
    endfunction

    // Timer oscillator and timer2 wake share this mode list; the async domain omits extended standby
    function automatic logic spr_async_listed(input spr_mode_e m);
        return (m == SPR_IDLE) || (m == SPR_ADCNR) || (m == SPR_PSAVE) || (m == SPR_XSTDBY);
    endfunction
endpackage

// ===== verilog/spr_wake_if.sv
// Wake qualification signals between the controller and its wake gate.
// Assumes all members are synchronous to hclk.
`timescale 1ns/10ps
interface spr_wake_if;
    import spr_pkg::*;
    spr_mode_e mode;
    logic asleep;
    logic t2_async;
    logic ext_a;
    logic ext_b;
    logic ext_a_lvl;
    logic ext_b_lvl;
    logic pin_chg;
    logic twi_match;
    logic wdt;
    logic t2;
    logic spm_ee;
    logic adc;
    logic other_io;
    logic wake;
    modport ctrl (output mode, asleep, t2_async, ext_a, ext_b, ext_a_lvl, ext_b_lvl,
        pin_chg, twi_match, wdt, t2, spm_ee, adc, other_io, input wake);
    modport gate (input mode, asleep, t2_async, ext_a, ext_b, ext_a_lvl, ext_b_lvl,
        pin_chg, twi_match, wdt, t2, spm_ee, adc, other_io, output wake);
endinterface

// ===== verilog/spr_wake_gate.sv
// Combinational wake qualification for the active sleep mode.
// Assumes sources are synchronous, active-high interrupt requests.
`timescale 1ns/10ps
module spr_wake_gate (
    // Wake qualification
    spr_wake_if.gate w
);
    import spr_pkg::*;
    logic idle;
    logic nr;
    logic ext_ok;
    logic t2_ok;
    always_comb begin
        idle = (w.mode == SPR_IDLE);
        nr = (w.mode == SPR_ADCNR);
        // Edge-sensed requests need a running I/O clock, so only Idle takes them
        ext_ok = (w.ext_a && (idle || w.ext_a_lvl)) || (w.ext_b && (idle || w.ext_b_lvl));
        t2_ok = w.t2 && (idle || (spr_async_listed(w.mode) && w.t2_async));
        w.wake = w.asleep && (ext_ok || w.pin_chg || w.twi_match || w.wdt || t2_ok
            || ((idle || nr) && (w.spm_ee || w.adc)) || (idle && w.other_io));
    end
endmodule // spr_wake_gate

// ===== verilog/spr_sleep_ctrl.sv
// Sleep mode controller and peripheral clock gate, top level.
// Assumes a single-master AHB-Lite bus and a core that pulses sleep_instr.
`timescale 1ns/10ps
module spr_sleep_ctrl #(
    parameter int unsigned STARTUP_CYCLES = spr_pkg::STARTUP_CYCLES_DEF
) (
    // Clock, reset, enable
    input logic hclk,
    input logic hresetn,
    input logic clk_en,
    // AHB-Lite slave
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Core
    input logic sleep_instr,
    input logic any_reset_req,
    output logic core_halt,
    output logic storage_hold,
    output logic sleep_nop,
    output logic wake_resume,
    output logic reset_restart,
    // Wake sources
    input logic external_irq_a,
    input logic external_irq_b,
    input logic ext_a_level_mode,
    input logic ext_b_level_mode,
    input logic pin_change_irq,
    input logic twowire_addr_match,
    input logic watchdog_irq,
    input logic timer2_irq,
    input logic spm_ee_ready_irq,
    input logic adc_irq,
    input logic other_io_irq,
    input logic timer2_async_select,
    // Clock domains and oscillators
    output logic cpu_clock_on,
    output logic io_clock_domain_on,
    output logic adc_clock_domain_on,
    output logic async_clock_on,
    output logic main_osc_on,
    output logic timer_osc_on,
    // Peripheral clocks
    output logic twowire_clk_on,
    output logic timer2_clk_on,
    output logic timer0_clk_on,
    output logic timer1_clk_on,
    output logic spi_clk_on,
    output logic usart_clk_on,
    output logic adc_clk_on,
    output logic comparator_mux_allowed
);
    import spr_pkg::*;

    localparam logic [CNT_W-1:0] START_LOAD = CNT_W'(STARTUP_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYCLES - 4'h1);

    logic sleep_enable_bit;
    spr_mode_e sleep_mode_field;
    logic [7:0] peripheral_clock_gate;
    spr_state_e state;
    spr_mode_e act_mode;
    logic [CNT_W-1:0] cnt;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic acc;
    logic [7:0] rd_val;
    logic gated;
    logic sleep_ok;
    logic [3:0] hold_seen;

    spr_wake_if wif();
    spr_wake_gate u_wake (
        .w(wif.gate)
    );

    assign wif.mode = act_mode;
    assign wif.asleep = (state == ST_SLEEP);
    assign wif.t2_async = timer2_async_select;
    assign wif.ext_a = external_irq_a;
    assign wif.ext_b = external_irq_b;
    assign wif.ext_a_lvl = ext_a_level_mode;
    assign wif.ext_b_lvl = ext_b_level_mode;
    assign wif.pin_chg = pin_change_irq;
    assign wif.twi_match = twowire_addr_match;
    assign wif.wdt = watchdog_irq;
    assign wif.t2 = timer2_irq;
    assign wif.spm_ee = spm_ee_ready_irq;
    assign wif.adc = adc_irq;
    assign wif.other_io = other_io_irq;

    // Stalling while clk_en is low keeps every transfer aligned with live state
    assign hreadyout = clk_en;
    assign hresp = 1'b0;
    assign acc = hsel && htrans[1] && hready && clk_en;

    always_comb begin
        case (haddr[7:0])
            SMC_OFS: rd_val = {4'h0, sleep_mode_field, sleep_enable_bit};
            PCG_OFS: rd_val = peripheral_clock_gate;
            STAT_OFS: rd_val = {timer2_async_select, act_mode, state};
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr <= 1'b0;
            dph_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (acc) begin
                dph_wr <= hwrite;
                dph_addr <= haddr[7:0];
                hrdata <= {24'h00_0000, rd_val};
            end else if (hready) begin
                dph_wr <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_enable_bit <= SMC_RESET[SE_POS];
            sleep_mode_field <= spr_mode_e'(SMC_RESET[MODE_MSB:MODE_LSB]);
            peripheral_clock_gate <= PCG_RESET;
        end else if (clk_en && dph_wr) begin
            if (dph_addr == SMC_OFS) begin
                sleep_enable_bit <= hwdata[SE_POS];
                sleep_mode_field <= spr_mode_e'(hwdata[MODE_MSB:MODE_LSB]);
            end
            if (dph_addr == PCG_OFS) begin
                peripheral_clock_gate <= hwdata[7:0] & PCG_MASK;
            end
        end
    end

    // Unlisted mode codes behave like a disabled sleep
    assign sleep_ok = sleep_enable_bit && spr_mode_ok(sleep_mode_field);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_RUN;
            act_mode <= SPR_IDLE;
            cnt <= '0;
            sleep_nop <= 1'b0;
            wake_resume <= 1'b0;
            reset_restart <= 1'b0;
        end else if (clk_en) begin
            sleep_nop <= 1'b0;
            wake_resume <= 1'b0;
            reset_restart <= 1'b0;
            case (state)
                ST_RUN: begin
                    if (sleep_instr && sleep_ok) begin
                        state <= ST_SLEEP;
                        act_mode <= sleep_mode_field;
                    end else if (sleep_instr) begin
                        sleep_nop <= 1'b1;
                    end
                end
                ST_SLEEP: begin
                    if (any_reset_req) begin
                        state <= ST_RUN;
                        reset_restart <= 1'b1;
                    end else if (wif.wake && act_mode == SPR_PDOWN) begin
                        state <= ST_START;
                        cnt <= START_LOAD;
                    end else if (wif.wake) begin
                        state <= ST_HOLD;
                        cnt <= HOLD_LOAD;
                    end
                end
                ST_START: begin
                    if (any_reset_req) begin
                        state <= ST_RUN;
                        reset_restart <= 1'b1;
                    end else if (cnt == '0) begin
                        state <= ST_HOLD;
                        cnt <= HOLD_LOAD;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (any_reset_req) begin
                        state <= ST_RUN;
                        reset_restart <= 1'b1;
                    end else if (cnt == '0) begin
                        state <= ST_RUN;
                        wake_resume <= 1'b1;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // Domains stay gated until start-up ends; the core holds storage while halted
    assign gated = (state == ST_SLEEP) || (state == ST_START);
    assign core_halt = (state != ST_RUN);
    assign storage_hold = core_halt;
    assign cpu_clock_on = (state == ST_RUN);
    assign io_clock_domain_on = !gated || (act_mode == SPR_IDLE);
    assign adc_clock_domain_on = !gated || (act_mode == SPR_IDLE) || (act_mode == SPR_ADCNR);
    assign async_clock_on = timer2_async_select && (!gated || (act_mode == SPR_IDLE)
        || (act_mode == SPR_ADCNR) || (act_mode == SPR_PSAVE));
    assign timer_osc_on = timer2_async_select && (!gated || spr_async_listed(act_mode));
    assign main_osc_on = (state != ST_SLEEP) || (act_mode != SPR_PDOWN);

    assign twowire_clk_on = io_clock_domain_on && !peripheral_clock_gate[PCG_TWI];
    assign timer2_clk_on = timer2_async_select ? async_clock_on
        : (io_clock_domain_on && !peripheral_clock_gate[PCG_T2]);
    assign timer0_clk_on = io_clock_domain_on && !peripheral_clock_gate[PCG_T0];
    assign timer1_clk_on = io_clock_domain_on && !peripheral_clock_gate[PCG_T1];
    // Debug shares the SPI clock path; software must leave this bit clear then
    assign spi_clk_on = io_clock_domain_on && !peripheral_clock_gate[PCG_SPI];
    assign usart_clk_on = io_clock_domain_on && !peripheral_clock_gate[PCG_USART];
    assign adc_clk_on = adc_clock_domain_on && !peripheral_clock_gate[PCG_ADC];
    assign comparator_mux_allowed = !peripheral_clock_gate[PCG_ADC];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_seen <= 4'h0;
        end else if (clk_en) begin
            if (state != ST_HOLD) begin
                hold_seen <= 4'h0;
            end else begin
                hold_seen <= hold_seen + 4'h1;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sleep_entry_a: assert property (state == ST_RUN && clk_en && sleep_instr && sleep_ok
        |=> state == ST_SLEEP && act_mode == $past(sleep_mode_field))
        else $error("sleep not entered on enabled sleep");
    sleep_nop_a: assert property (state == ST_RUN && clk_en && sleep_instr && !sleep_enable_bit
        |=> state == ST_RUN && sleep_nop ##1 !sleep_nop || !clk_en)
        else $error("disabled sleep not a single no-op");
    hold_four_a: assert property (state == ST_HOLD && clk_en && cnt == '0 && !any_reset_req
        |-> hold_seen == 4'h3 ##1 wake_resume && state == ST_RUN)
        else $error("wake hold not four cycles");
    retain_sleep_a: assert property (state == ST_SLEEP
        |-> storage_hold && core_halt && !cpu_clock_on)
        else $error("storage not held while asleep");
    reset_wake_a: assert property (state != ST_RUN && clk_en && any_reset_req
        |=> state == ST_RUN && reset_restart && !wake_resume)
        else $error("reset during sleep did not restart");
    wake_hold_a: assert property (state == ST_SLEEP && clk_en && !any_reset_req && wif.wake
        && act_mode != SPR_PDOWN |=> state == ST_HOLD && cnt == HOLD_LOAD)
        else $error("wake did not start the hold");
    idle_gate_a: assert property (state == ST_SLEEP && act_mode == SPR_IDLE
        |-> !cpu_clock_on && io_clock_domain_on && adc_clock_domain_on)
        else $error("idle gating wrong");
    deep_gate_a: assert property (state == ST_SLEEP && (act_mode == SPR_PDOWN
        || act_mode == SPR_STDBY || act_mode == SPR_XSTDBY)
        |-> !io_clock_domain_on && !adc_clock_domain_on && !async_clock_on)
        else $error("deep sleep domain not stopped");
    edge_ignore_a: assert property (state == ST_SLEEP && act_mode != SPR_IDLE && clk_en
        && !any_reset_req && external_irq_a && !ext_a_level_mode && !external_irq_b
        && !pin_change_irq && !twowire_addr_match && !watchdog_irq
        && (!timer2_irq || !timer2_async_select)
        && !spm_ee_ready_irq && !adc_irq && !other_io_irq |=> state == ST_SLEEP)
        else $error("edge interrupt woke deep sleep");
    async_need_a: assert property (!timer2_async_select
        |-> !async_clock_on && !timer_osc_on)
        else $error("async clock without async mode");
    timer2_off_a: assert property (peripheral_clock_gate[PCG_T2] && !timer2_async_select
        |-> !timer2_clk_on)
        else $error("timer2 clock not stopped");
    gate_map_a: assert property (state == ST_RUN
        |-> twowire_clk_on == !peripheral_clock_gate[PCG_TWI]
        && timer0_clk_on == !peripheral_clock_gate[PCG_T0]
        && timer1_clk_on == !peripheral_clock_gate[PCG_T1]
        && spi_clk_on == !peripheral_clock_gate[PCG_SPI]
        && usart_clk_on == !peripheral_clock_gate[PCG_USART])
        else $error("peripheral clock gate mismatch");
    gate_write_a: assert property (clk_en && dph_wr && dph_addr == PCG_OFS
        |=> peripheral_clock_gate == ($past(hwdata[7:0]) & PCG_MASK))
        else $error("gate register write lost");
    adc_mux_a: assert property (peripheral_clock_gate[PCG_ADC]
        |-> !comparator_mux_allowed && !adc_clk_on)
        else $error("comparator mux open with adc off");

    idle_enter_c: cover property (state == ST_RUN && sleep_instr && sleep_ok
        && sleep_mode_field == SPR_IDLE ##1 state == ST_SLEEP);
    pdown_wake_c: cover property (state == ST_START ##1 state == ST_HOLD);
    resume_c: cover property (wake_resume);
    reset_wake_c: cover property (reset_restart);
    level_wake_c: cover property (state == ST_SLEEP && act_mode != SPR_IDLE
        && external_irq_a && ext_a_level_mode ##1 state == ST_HOLD);
endmodule // spr_sleep_ctrl

// ===== testbench/spr_core_model.sv
// Core-side model: issues sleep on request and counts returns to run.
// Assumes the bench pulses issue for one cycle just after a rising edge.
`timescale 1ns/10ps
module spr_core_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench request
    input wire logic issue,
    // Controller side
    input wire logic core_halt,
    input wire logic wake_resume,
    input wire logic reset_restart,
    output logic sleep_instr,
    output logic [7:0] returns
);
    // A halted core fetches nothing, so it cannot issue sleep
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_instr <= 1'b0;
        end else begin
            sleep_instr <= issue && !core_halt;
        end
    end

    // Every return to run, by interrupt or by reset, is counted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            returns <= 8'h00;
        end else begin
            returns <= returns + 8'(wake_resume | reset_restart);
        end
    end
endmodule // spr_core_model

// ===== testbench/tb.sv
// Self-checking bench of the sleep and power reduction controller.
// Assumes the core model beside it and one AHB-Lite master in this module.
`timescale 1ns/10ps
module tb;
    import spr_pkg::*;
    localparam int STARTUP = 2;
    logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic issue = 1'b0, rst_req = 1'b0, ext_a = 1'b0, ext_b = 1'b0, lvl_a = 1'b0;
    logic lvl_b = 1'b0, spq = 1'b0, t2as = 1'b0;
    logic [5:0] src = 6'h0;
    logic hreadyout, hresp, sleep_instr, core_halt, storage_hold, sleep_nop;
    logic wake_resume, reset_restart, cpu_clock_on, cmp_ok;
    logic [4:0] dom;
    logic [6:0] pclk;
    logic [7:0] returns;
    int fail_count = 0;
    int n_compared = 0;

    spr_sleep_ctrl #(.STARTUP_CYCLES(STARTUP)) dut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sleep_instr(sleep_instr), .any_reset_req(rst_req), .core_halt(core_halt),
        .storage_hold(storage_hold), .sleep_nop(sleep_nop), .wake_resume(wake_resume),
        .reset_restart(reset_restart), .external_irq_a(ext_a), .external_irq_b(ext_b),
        .ext_a_level_mode(lvl_a), .ext_b_level_mode(lvl_b), .pin_change_irq(src[2]),
        .twowire_addr_match(src[4]), .watchdog_irq(src[5]), .timer2_irq(src[3]),
        .spm_ee_ready_irq(spq), .adc_irq(src[1]), .other_io_irq(src[0]),
        .timer2_async_select(t2as), .cpu_clock_on(cpu_clock_on),
        .io_clock_domain_on(dom[4]), .adc_clock_domain_on(dom[3]),
        .async_clock_on(dom[2]), .main_osc_on(dom[1]), .timer_osc_on(dom[0]),
        .twowire_clk_on(pclk[6]), .timer2_clk_on(pclk[5]), .timer0_clk_on(pclk[4]),
        .timer1_clk_on(pclk[3]), .spi_clk_on(pclk[2]), .usart_clk_on(pclk[1]),
        .adc_clk_on(pclk[0]), .comparator_mux_allowed(cmp_ok)
    );

    spr_core_model core (
        .hclk(hclk), .hresetn(hresetn), .issue(issue), .core_halt(core_halt),
        .wake_resume(wake_resume), .reset_restart(reset_restart),
        .sleep_instr(sleep_instr), .returns(returns)
    );

    always #2 hclk = ~hclk;

    task automatic final_report();
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bounded wait so a stuck bus shows up as a mismatch, not a hang
    task automatic wait_ready();
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) fail_count++;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] x;
        ahb(1'b1, a, {24'h0, d}, x);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        check(what, x, exp);
    endtask

    task automatic go_sleep(input logic [2:0] m, input logic en);
        wr(SMC_OFS, {4'h0, m, en});
        issue <= 1'b1;
        @(posedge hclk);
        issue <= 1'b0;
        @(posedge hclk);
        #1;
    endtask

    task automatic wake_count(output int n);
        n = 0;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (wake_resume !== 1'b1 && n < 60);
    endtask

    task automatic t_regs();
        logic [6:0] exp7;
        rd_chk("gate reset", PCG_OFS, 32'h0);
        rd_chk("mode reset", SMC_OFS, 32'h0);
        rd_chk("unmapped", 8'h70, 32'h0);
        check("bus response", {31'h0, hresp}, 32'h0);
        // ADC is taken as idle before its gate bit is set; SPI debug unused
        for (int b = 0; b < 8; b++) begin
            if (b != 4) begin
                wr(PCG_OFS, 8'(1 << b));
                #1;
                exp7 = 7'(1 << (b > 4 ? b - 1 : b));
                check("periph clocks", {25'h0, pclk},
                      {25'h0, ~exp7});
                check("comparator mux", {31'h0, cmp_ok}, {31'h0, b != 0});
            end
        end
        wr(PCG_OFS, 8'hff);
        rd_chk("gate mask", PCG_OFS, 32'hef);
        t2as <= 1'b1;
        #1;
        check("timer2 async", {31'h0, pclk[5]}, 32'h1);
        wr(PCG_OFS, 8'h00);
        #1;
        check("clocks back", {25'h0, pclk}, 32'h7f);
    endtask

    task automatic t_nop();
        go_sleep(3'h0, 1'b0);
        check("nop disabled", {30'h0, sleep_nop, core_halt}, 32'h2);
        go_sleep(3'h4, 1'b1);
        check("nop bad mode", {30'h0, sleep_nop, core_halt}, 32'h2);
    endtask

    // One wake source per mode, each one allowed in that mode
    task automatic t_modes();
        logic [2:0] m [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
        logic [4:0] e [6] = '{5'h1f, 5'h0f, 5'h00, 5'h07, 5'h02, 5'h03};
        int n;
        for (int i = 0; i < 6; i++) begin
            go_sleep(m[i], 1'b1);
            check("halt hold", {30'h0, core_halt, storage_hold}, 32'h3);
            check("cpu clock", {31'h0, cpu_clock_on}, 32'h0);
            check("domains", {27'h0, dom}, {27'h0, e[i]});
            rd_chk("status", STAT_OFS, {24'h0, 1'b1, m[i], 4'h2});
            src <= 6'(1 << i);
            wake_count(n);
            src <= 6'h0;
            check("wake delay", n, (i == 2) ? 5 + STARTUP : 5);
        end
    endtask

    task automatic t_ext();
        int n;
        t2as <= 1'b0;
        go_sleep(3'h3, 1'b1);
        check("psave no async", {27'h0, dom}, 32'h02);
        ext_a <= 1'b1;
        src <= 6'h08;
        repeat (8) @(posedge hclk);
        #1;
        check("edge no wake", {31'h0, core_halt}, 32'h1);
        lvl_a <= 1'b1;
        wake_count(n);
        check("level wake", n, 5);
        ext_a <= 1'b0;
        lvl_a <= 1'b0;
        src <= 6'h0;
        go_sleep(3'h0, 1'b1);
        ext_b <= 1'b1;
        wake_count(n);
        ext_b <= 1'b0;
        check("idle edge wake", n, 5);
    endtask

    // Clock enable low must freeze the sleeping state even with a wake pending
    task automatic t_freeze();
        int n;
        go_sleep(3'h0, 1'b1);
        clk_en <= 1'b0;
        src <= 6'h01;
        repeat (3) @(posedge hclk);
        #1;
        check("frozen sleep", {31'h0, core_halt}, 32'h1);
        clk_en <= 1'b1;
        wake_count(n);
        src <= 6'h0;
        check("wake after freeze", n, 5);
    endtask

    task automatic t_reset();
        go_sleep(3'h6, 1'b1);
        rst_req <= 1'b1;
        @(posedge hclk);
        #1;
        rst_req <= 1'b0;
        check("reset restart", {30'h0, reset_restart, core_halt}, 32'h2);
    endtask

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_nop();
        t_modes();
        t_ext();
        t_freeze();
        t_reset();
        // The core model counts the last restart pulse one edge later
        @(posedge hclk);
        #1;
        check("returns", {24'h0, returns}, 32'd10);
        final_report();
    end

    // Whole run needs well under a thousand cycles; the 25000-cycle limit leaves wide margin
    initial begin
        #100000;
        fail_count++;
        final_report();
    end
endmodule // tb
